// ==== rtl/psi_pkg.sv ====
// psi_pkg: constants and types of the status indicator and i/o override block.
// assumes a 100 MHz system clock and a classic wishbone register port.
//
// Contract
// - disabled input keeps scanning but ignores the physical input value
// - disabled output ignores the logic scan result
// - disabled points take a user forced on/off value, held until changed
// - re-enabled points resume following external inputs and scan outputs
// - supply lamp on while supply normal, off in overload low-voltage mode
// - healthy and stopped: run lamp on 2 s, off 2 s
// - running: run lamp on 0.25 s, off 0.25 s
// - tool-selected run/stop kept non-volatile and restored after power cycle
// - cartridge fitted and syntax good: enter run at power-up
// - watchdog or program fault: switch to stop and light error lamp
// - after minor error, power cycle may return the unit to run
// - after serious error, tool operations refused until fault cleared; only tool writes are refused here, reads are still answered
// - no error: error lamp off; steady error lamp means system error
// - error code reported: error lamp flashes at 0.5 s interval
// - code reported: lowest four output lamps show code, outputs disabled
// - code in binary, fourth lamp msb; codes 1..10 defined, 11..15 reserved
// - rx and tx lamps lit exactly while reception or transmission lasts
// - built-in port is slave only, never starts a transaction
// - reply transmitted only after a request has been received
// - input lamp lit while its external input is on
// - output lamp lit while the output is driven on
package psi_pkg;

  // clock and blink timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
  localparam int unsigned RUN_HALF_MS = 250;
  localparam int unsigned ERR_HALF_MS = 500;
  localparam int unsigned STOP_HALF_MS = 2000;
  localparam int unsigned BASE_CYC = CLK_PER_MS * RUN_HALF_MS;
  localparam int unsigned ERR_SHIFT = $clog2(ERR_HALF_MS / RUN_HALF_MS);
  localparam int unsigned STOP_SHIFT = $clog2(STOP_HALF_MS / RUN_HALF_MS);
  localparam int unsigned PH_W = STOP_SHIFT + 1;

  // register word offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_IN_DIS = 8'h08;
  localparam logic [7:0] OFS_IN_FRC = 8'h0C;
  localparam logic [7:0] OFS_OUT_DIS = 8'h10;
  localparam logic [7:0] OFS_OUT_FRC = 8'h14;
  localparam logic [7:0] OFS_IN_IMG = 8'h18;
  localparam logic [7:0] OFS_OUT_IMG = 8'h1C;

  // field positions
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_CLR = 1;
  localparam int unsigned STAT_RUN = 0;
  localparam int unsigned STAT_CODE_LO = 4;
  localparam int unsigned STAT_ACT = 8;
  localparam int unsigned STAT_SYS = 9;
  localparam int unsigned STAT_SER = 10;
  localparam int unsigned STAT_NV = 11;

  // error codes shown on the code display lamps
  localparam int unsigned CODE_W = 4;
  localparam logic [3:0] CODE_NONE = 4'h0;
  localparam logic [3:0] CODE_UNSUP = 4'h1;
  localparam logic [3:0] CODE_ID = 4'h2;
  localparam logic [3:0] CODE_CSUM = 4'h3;
  localparam logic [3:0] CODE_STACK = 4'h4;
  localparam logic [3:0] CODE_WDOG = 4'h5;
  localparam logic [3:0] CODE_MAIN_IO = 4'h6;
  localparam logic [3:0] CODE_SYNTAX = 4'h7;
  localparam logic [3:0] CODE_MOD_CNT = 4'h8;
  localparam logic [3:0] CODE_PT_CNT = 4'h9;
  localparam logic [3:0] CODE_FLASH = 4'hA;

  // run/stop mode, one-hot
  typedef enum logic [1:0] {
    MODE_STOP = 2'b01,
    MODE_RUN = 2'b10
  } psi_mode_type;

endpackage

// ==== rtl/psi_blink_if.sv ====
// psi_blink_if: blink phases passed from the timer to the lamp logic.
// assumes one clock domain; phases are levels, low is the off phase.
`timescale 1ns/1ps
`default_nettype none
interface psi_blink_if;
  logic run_ph;
  logic err_ph;
  logic stop_ph;
  modport src (output run_ph, output err_ph, output stop_ph);
  modport dst (input run_ph, input err_ph, input stop_ph);
endinterface
`default_nettype wire

// ==== rtl/psi_blink.sv ====
// psi_blink: free-running lamp blink timer.
// assumes clk_i at CLK_HZ and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module psi_blink
  import psi_pkg::*;
#(
  parameter int unsigned BASE = BASE_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // phases out
  psi_blink_if.src bl
);
  localparam int unsigned CW = (BASE > 1) ? $clog2(BASE) : 1;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [PH_W-1:0] ph;
  } psi_blink_st_type;

  psi_blink_st_type s_q, s_d;

  if (BASE < 2) begin : g_chk
    $error("psi_blink: BASE must be at least 2");
  end

  // base tick every quarter second; phase bits divide it by powers of two
  always_comb begin
    s_d = s_q;
    if (s_q.cnt == CW'(BASE - 1)) begin
      s_d.cnt = '0;
      s_d.ph = s_q.ph + PH_W'(1);
    end else begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  // reset puts every phase in its off half
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bl.run_ph = s_q.ph[0];
  assign bl.err_ph = s_q.ph[ERR_SHIFT];
  assign bl.stop_ph = s_q.ph[STOP_SHIFT];
endmodule
`default_nettype wire

// ==== rtl/psi_top.sv ====
// psi_top: status lamps, run/stop keeping and per-point i/o disable/force.
// assumes synchronous inputs from the scan engine, port and supply monitor,
// and a classic wishbone master for the programming tool.
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module psi_top
  import psi_pkg::*;
#(
  parameter int unsigned N_IN = 16,
  parameter int unsigned N_OUT = 16,
  parameter int unsigned BLINK_BASE_CYC = BASE_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // scan engine
  input wire logic [N_IN-1:0] ext_in_i,
  input wire logic [N_OUT-1:0] scan_out_i,
  output logic [N_IN-1:0] in_image_o,
  output logic [N_OUT-1:0] phys_out_o,
  output logic run_o,
  // faults
  input wire logic err_event_i,
  input wire logic [3:0] err_code_i,
  input wire logic err_serious_i,
  input wire logic sys_err_i,
  input wire logic fault_clear_i,
  // power-up sources
  input wire logic nv_run_i,
  input wire logic cartridge_fitted_i,
  input wire logic cartridge_syntax_ok_i,
  output logic nv_run_o,
  // supply monitor
  input wire logic supply_good_i,
  input wire logic overload_i,
  // built-in comm port
  input wire logic rx_active_i,
  input wire logic tx_active_i,
  output logic reply_permit_o,
  // front panel lamps
  output logic supply_ok_lamp_o,
  output logic run_lamp_o,
  output logic err_lamp_o,
  output logic rx_lamp_o,
  output logic tx_lamp_o,
  output logic [N_IN-1:0] input_point_lamp_o,
  output logic [N_OUT-1:0] output_point_lamp_o
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks

  if (N_IN < 1 || N_IN > 32) begin : g_chk_in
    $error("psi_top: N_IN must be 1..32");
  end
  if (N_OUT < CODE_W || N_OUT > 32) begin : g_chk_out
    $error("psi_top: N_OUT must be 4..32");
  end

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    psi_mode_type mode;
    logic boot;
    logic serious;
    logic sys_err;
    logic [CODE_W-1:0] code;
    logic nv_run;
    logic [N_IN-1:0] in_dis;
    logic [N_IN-1:0] in_frc;
    logic [N_IN-1:0] in_img;
    logic [N_IN-1:0] in_lamp;
    logic [N_OUT-1:0] out_dis;
    logic [N_OUT-1:0] out_frc;
    logic [N_OUT-1:0] out_img;
    logic [N_OUT-1:0] out_lamp;
    logic [N_OUT-1:0] phys;
    logic supply_ok_lamp;
    logic run_lamp;
    logic err_lamp;
    logic rx_lamp;
    logic tx_lamp;
    logic permit;
  } psi_top_st_type;

  psi_top_st_type s_q, s_d;

  psi_blink_if bl ();

  // blink timer
  psi_blink #(
    .BASE(BLINK_BASE_CYC)
  ) u_blink (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bl(bl)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus decode helpers

  logic req;
  logic wr;
  logic locked;
  logic [31:0] wmask;
  logic [31:0] in_pad;
  logic [31:0] out_pad;
  logic [N_OUT-1:0] code_mask;
  logic [N_OUT-1:0] code_bits;

  // a request is taken once; ack drops the cycle after it was given
  assign req = cyc_i & stb_i & ~s_q.ack;
  assign wr = req & we_i;
  // serious fault locks out every tool write
  assign locked = s_q.serious;
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign code_mask = N_OUT'({CODE_W{1'b1}});
  assign code_bits = N_OUT'(s_q.code);

  // byte-lane merge of a write into a narrow register
  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~wmask) | (dat_i & wmask);
  endfunction

  assign in_pad = 32'(s_q.in_dis);
  assign out_pad = 32'(s_q.out_dis);

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic code_act;
    logic healthy;
    code_act = 1'b0;
    healthy = 1'b0;
    s_d = s_q;
    s_d.ack = req;
    s_d.boot = 1'b0;

    // power-up: cartridge wins, else the retained mode comes back
    if (s_q.boot) begin
      if (cartridge_fitted_i) begin
        s_d.mode = cartridge_syntax_ok_i ? MODE_RUN : MODE_STOP;
        if (!cartridge_syntax_ok_i) begin
          s_d.code = CODE_SYNTAX;
        end
      end else begin
        s_d.mode = nv_run_i ? MODE_RUN : MODE_STOP;
      end
      s_d.nv_run = nv_run_i;
    end

    // register writes from the tool
    if (wr && !locked) begin
      unique case (adr_i)
        OFS_CTRL: begin
          if (sel_i[0]) begin
            s_d.mode = dat_i[CTRL_RUN] ? MODE_RUN : MODE_STOP;
            s_d.nv_run = dat_i[CTRL_RUN];
            if (dat_i[CTRL_CLR]) begin
              s_d.code = CODE_NONE;
            end
          end
        end
        OFS_IN_DIS: s_d.in_dis = N_IN'(merge(in_pad));
        OFS_IN_FRC: s_d.in_frc = N_IN'(merge(32'(s_q.in_frc)));
        OFS_OUT_DIS: s_d.out_dis = N_OUT'(merge(out_pad));
        OFS_OUT_FRC: s_d.out_frc = N_OUT'(merge(32'(s_q.out_frc)));
        default: begin
        end
      endcase
    end

    // read data, unmapped reads as zero
    s_d.rdat = '0;
    if (req && !we_i) begin
      unique case (adr_i)
        OFS_CTRL: s_d.rdat[CTRL_RUN] = (s_q.mode == MODE_RUN);
        OFS_STAT: begin
          s_d.rdat[STAT_RUN] = (s_q.mode == MODE_RUN);
          s_d.rdat[STAT_CODE_LO +: CODE_W] = s_q.code;
          s_d.rdat[STAT_ACT] = (s_q.code != CODE_NONE);
          s_d.rdat[STAT_SYS] = s_q.sys_err;
          s_d.rdat[STAT_SER] = s_q.serious;
          s_d.rdat[STAT_NV] = s_q.nv_run;
        end
        OFS_IN_DIS: s_d.rdat = in_pad;
        OFS_IN_FRC: s_d.rdat = 32'(s_q.in_frc);
        OFS_OUT_DIS: s_d.rdat = out_pad;
        OFS_OUT_FRC: s_d.rdat = 32'(s_q.out_frc);
        OFS_IN_IMG: s_d.rdat = 32'(s_q.in_img);
        OFS_OUT_IMG: s_d.rdat = 32'(s_q.out_img);
        default: s_d.rdat = '0;
      endcase
    end

    // fault clearing first, so a fault in the same cycle still lands
    if (fault_clear_i) begin
      s_d.serious = 1'b0;
    end
    s_d.sys_err = sys_err_i;
    if (sys_err_i) begin
      s_d.mode = MODE_STOP;
    end
    if (err_event_i) begin
      s_d.mode = MODE_STOP;
      if (err_code_i != CODE_NONE) begin
        s_d.code = err_code_i;
      end
      if (err_serious_i) begin
        s_d.serious = 1'b1;
        s_d.nv_run = 1'b0;
      end
      // minor: the retained run stays, so a power cycle resumes run
    end

    // input image: disabled points hold their forced value
    s_d.in_img = (ext_in_i & ~s_q.in_dis) | (s_q.in_frc & s_q.in_dis);
    // output image: disabled points ignore the scan result
    s_d.out_img = (scan_out_i & ~s_q.out_dis) | (s_q.out_frc & s_q.out_dis);

    // code display borrows the four lowest output lamps
    code_act = (s_d.code != CODE_NONE);
    if (code_act) begin
      s_d.out_lamp = (s_d.out_img & ~code_mask) | N_OUT'(s_d.code);
      s_d.phys = s_d.out_img & ~code_mask;
    end else begin
      s_d.out_lamp = s_d.out_img;
      s_d.phys = s_d.out_img;
    end
    s_d.in_lamp = ext_in_i;

    // lamps
    s_d.supply_ok_lamp = supply_good_i & ~overload_i;
    healthy = ~s_d.sys_err;
    if (s_d.mode == MODE_RUN) begin
      s_d.run_lamp = bl.run_ph;
    end else begin
      s_d.run_lamp = healthy & bl.stop_ph;
    end
    if (s_d.sys_err) begin
      s_d.err_lamp = 1'b1;
    end else if (code_act) begin
      s_d.err_lamp = bl.err_ph;
    end else begin
      s_d.err_lamp = 1'b0;
    end
    s_d.rx_lamp = rx_active_i;
    s_d.tx_lamp = tx_active_i;

    // slave-only port: a reply is permitted only once a request came in;
    // the permit ends when the reply finishes
    if (rx_active_i) begin
      s_d.permit = 1'b1;
    end else if (s_q.tx_lamp && !tx_active_i) begin
      s_d.permit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  // boot flag starts the power-up restore one cycle after release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.mode <= MODE_STOP;
      s_q.boot <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops, run_o decoded from the mode flip-flops

  assign dat_o = s_q.rdat;
  assign ack_o = s_q.ack;
  assign in_image_o = s_q.in_img;
  assign phys_out_o = s_q.phys;
  assign run_o = (s_q.mode == MODE_RUN);
  assign nv_run_o = s_q.nv_run;
  assign reply_permit_o = s_q.permit;
  assign supply_ok_lamp_o = s_q.supply_ok_lamp;
  assign run_lamp_o = s_q.run_lamp;
  assign err_lamp_o = s_q.err_lamp;
  assign rx_lamp_o = s_q.rx_lamp;
  assign tx_lamp_o = s_q.tx_lamp;
  assign input_point_lamp_o = s_q.in_lamp;
  assign output_point_lamp_o = s_q.out_lamp;

endmodule
`default_nettype wire

// ==== testbench/psi_asserts.sv ====
// psi_asserts: port checks of the status lamp block.
// assumes a bind into psi_top, one clock, sync active-high reset.
`timescale 1ns/1ps
`default_nettype none
module psi_asserts
  import psi_pkg::*;
#(
  parameter int unsigned N_IN = 16,
  parameter int unsigned N_OUT = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // causes
  input wire logic [N_IN-1:0] ext_in_i,
  input wire logic err_event_i,
  input wire logic [3:0] err_code_i,
  input wire logic sys_err_i,
  input wire logic supply_good_i,
  input wire logic overload_i,
  input wire logic rx_active_i,
  input wire logic tx_active_i,
  // effects
  input wire logic [N_OUT-1:0] phys_out_o,
  input wire logic run_o,
  input wire logic reply_permit_o,
  input wire logic supply_ok_lamp_o,
  input wire logic run_lamp_o,
  input wire logic err_lamp_o,
  input wire logic rx_lamp_o,
  input wire logic tx_lamp_o,
  input wire logic [N_IN-1:0] input_point_lamp_o,
  input wire logic [N_OUT-1:0] output_point_lamp_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////
  // lamps lag their cause by one clock; the first edge after reset is skipped
  supply_lamp_a: assert property (!$past(rst_i) |->
    supply_ok_lamp_o == $past(supply_good_i && !overload_i))
    else $error("supply lamp wrong");
  port_lamps_a: assert property (!$past(rst_i) |->
    rx_lamp_o == $past(rx_active_i) && tx_lamp_o == $past(tx_active_i))
    else $error("port lamps wrong");
  input_lamps_a: assert property (!$past(rst_i) |->
    input_point_lamp_o == $past(ext_in_i))
    else $error("input lamps wrong");
  sys_err_lamp_a: assert property (!$past(rst_i) && $past(sys_err_i) |->
    err_lamp_o)
    else $error("error lamp not steady");
  // faults stop the unit and put the code on the low lamps; replies wait for a request; run and error lamps off after reset
  fault_stop_a: assert property (err_event_i |=> !run_o)
    else $error("fault did not stop");
  code_show_a: assert property (err_event_i && err_code_i != 4'h0 |=>
    output_point_lamp_o[3:0] == $past(err_code_i) && phys_out_o[3:0] == 4'h0)
    else $error("code display wrong");
  reply_gate_a: assert property ($rose(reply_permit_o) |-> $past(rx_active_i))
    else $error("reply before request");
  reset_off_a: assert property ($fell(rst_i) |-> !run_lamp_o && !err_lamp_o)
    else $error("lamp on after reset");
  ////////////////////////////////////////////////////////////////
  // main scenarios reached
  cover property (err_event_i ##1 !run_o);
  cover property ($rose(reply_permit_o));
  cover property ($rose(run_lamp_o) && run_o);
endmodule

bind psi_top psi_asserts #(.N_IN(N_IN), .N_OUT(N_OUT)) u_psi_asserts (
  .clk_i, .rst_i, .ext_in_i, .err_event_i, .err_code_i, .sys_err_i, .supply_good_i,
  .overload_i, .rx_active_i, .tx_active_i, .phys_out_o, .run_o, .reply_permit_o,
  .supply_ok_lamp_o, .run_lamp_o, .err_lamp_o, .rx_lamp_o, .tx_lamp_o,
  .input_point_lamp_o, .output_point_lamp_o);
`default_nettype wire

// ==== testbench/psi_port_model.sv ====
// psi_port_model: far party on the built-in port and the unit's transmitter.
// assumes one go pulse per exchange; the reply waits for the permit.
`timescale 1ns/1ps
`default_nettype none
module psi_port_model #(
  parameter int RXN = 5,
  parameter int TXN = 7,
  parameter int DLY = 3
) (
  // clock and control
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic permit_i,
  // port activity
  output logic rx_o,
  output logic tx_o
);
  int n = 0;
  int s = 0;
  initial begin
    rx_o = 1'h0;
    tx_o = 1'h0;
  end
  // request, a slow turnaround, then the reply once granted
  always @(posedge clk_i) begin
    if (s == 0 && go_i) begin
      rx_o <= 1'h1;
      n <= RXN;
      s <= 1;
    end else if (s == 1 || s == 3) begin
      n <= (n == 1) ? DLY : n - 1;
      if (n == 1) begin
        rx_o <= 1'h0;
        tx_o <= 1'h0;
        s <= (s == 1) ? 2 : 0;
      end
    end else if (s == 2) begin
      if (n <= 0 && permit_i) begin
        tx_o <= 1'h1;
        n <= TXN;
        s <= 3;
      end else begin
        n <= n - 1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/psi_top_tb.sv ====
// psi_top_tb: directed bench of the status lamp and i/o override block.
// assumes psi_asserts is bound in and the port model drives rx/tx.
`timescale 1ns/1ps
`default_nettype none
module psi_top_tb
  import psi_pkg::*;
;
  localparam int B = 8;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF, err_code_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic [15:0] ext_in_i = 16'h0, scan_out_i = 16'h0, in_image_o, phys_out_o;
  logic [15:0] input_point_lamp_o, output_point_lamp_o;
  logic err_event_i = 1'h0, err_serious_i = 1'h0, sys_err_i = 1'h0;
  logic fault_clear_i = 1'h0, nv_run_i = 1'h1, go = 1'h0;
  logic cartridge_fitted_i = 1'h0, cartridge_syntax_ok_i = 1'h0;
  logic supply_good_i = 1'h1, overload_i = 1'h0;
  logic ack_o, run_o, nv_run_o, rx_active_i, tx_active_i, reply_permit_o;
  logic supply_ok_lamp_o, run_lamp_o, err_lamp_o, rx_lamp_o, tx_lamp_o;
  logic [7:0] ra [5] = '{OFS_IN_DIS, OFS_IN_FRC, OFS_OUT_DIS, OFS_OUT_FRC, 8'h40};
  int num_errors = 0, checks = 0, cycles = 0, g, n, m;

  psi_top #(.BLINK_BASE_CYC(B)) u_psi_top (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .ext_in_i, .scan_out_i, .in_image_o, .phys_out_o, .run_o, .err_event_i,
    .err_code_i, .err_serious_i, .sys_err_i, .fault_clear_i, .nv_run_i,
    .cartridge_fitted_i, .cartridge_syntax_ok_i, .nv_run_o, .supply_good_i,
    .overload_i, .rx_active_i, .tx_active_i, .reply_permit_o, .supply_ok_lamp_o,
    .run_lamp_o, .err_lamp_o, .rx_lamp_o, .tx_lamp_o, .input_point_lamp_o,
    .output_point_lamp_o);
  psi_port_model u_psi_port_model (.clk_i(clk_i), .go_i(go),
    .permit_i(reply_permit_o), .rx_o(rx_active_i), .tx_o(tx_active_i));

  ////////////////////////////////////////////////////////////////
  // clock and hang guard, far above the few hundred cycles needed
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  // one classic cycle; read data lands in q, then one idle cycle
  // no wait limit of its own: a lost ack is caught by the hang guard
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'h1);
    q = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic fault(input logic [3:0] c, input logic s);
    err_event_i <= 1'h1;
    err_code_i <= c;
    err_serious_i <= s;
    @(posedge clk_i);
    err_event_i <= 1'h0;
    err_serious_i <= 1'h0;
    @(posedge clk_i);
  endtask
  // reset held eight cycles, with the power-up sources set first
  task automatic power_up(input logic nv, input logic cf, input logic ok);
    rst_i <= 1'h1;
    nv_run_i <= nv;
    cartridge_fitted_i <= cf;
    cartridge_syntax_ok_i <= ok;
    tick(8);
    rst_i <= 1'h0;
    tick(3);
  endtask
  // edges from one lamp change to the next, after a partial first phase
  task automatic lamp_gap(input logic e, output int p);
    logic a;
    a = e ? err_lamp_o : run_lamp_o;
    for (int k = 0; k < 2; k++) begin
      p = 0;
      do begin
        @(posedge clk_i);
        p++;
      end while ((e ? err_lamp_o : run_lamp_o) === a && p < 200);
      a = ~a;
    end
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    power_up(1'h1, 1'h0, 1'h0);
    check(run_o, 1'h1);
    foreach (ra[i]) begin
      wb(1'h0, ra[i], 32'h0);
      check(q, 32'h0);
    end
    ext_in_i <= 16'hA5C3;
    tick(2);
    check(in_image_o, 16'hA5C3);
    wb(1'h1, OFS_IN_DIS, 32'h00FF);
    wb(1'h1, OFS_IN_FRC, 32'h0F0F);
    ext_in_i <= 16'h5A3C;
    tick(2);
    check(in_image_o, 16'h5A0F);
    check(input_point_lamp_o, 16'h5A3C);
    wb(1'h0, OFS_IN_IMG, 32'h0);
    check(q, 32'h5A0F);
    wb(1'h1, OFS_IN_DIS, 32'h0);
    tick(1);
    check(in_image_o, 16'h5A3C);
    wb(1'h1, OFS_OUT_DIS, 32'hF0F0);
    wb(1'h1, OFS_OUT_FRC, 32'hAAAA);
    scan_out_i <= 16'h1234;
    tick(2);
    check(phys_out_o, 16'hA2A4);
    check(output_point_lamp_o, 16'hA2A4);
    wb(1'h0, OFS_OUT_IMG, 32'h0);
    check(q, 32'hA2A4);
    wb(1'h1, OFS_OUT_DIS, 32'h0);
    tick(1);
    check(phys_out_o, 16'h1234);
    lamp_gap(1'h0, g);
    check(g, B);
    // every code, each cleared but the last
    for (int c = 1; c < 16; c++) begin
      fault(c[3:0], 1'h0);
      check(run_o, 1'h0);
      check(output_point_lamp_o[3:0], c[3:0]);
      check(phys_out_o[3:0], 4'h0);
      if (c < 15) wb(1'h1, OFS_CTRL, 32'h2);
    end
    lamp_gap(1'h1, g);
    check(g, 2 * B);
    wb(1'h1, OFS_CTRL, 32'h2);
    tick(2);
    check(err_lamp_o, 1'h0);
    check(phys_out_o, 16'h1234);
    lamp_gap(1'h0, g);
    check(g, 8 * B);
    sys_err_i <= 1'h1;
    tick(20);
    check(err_lamp_o, 1'h1);
    sys_err_i <= 1'h0;
    wb(1'h1, OFS_CTRL, 32'h1);
    fault(4'h5, 1'h0);
    check(nv_run_o, 1'h1);
    power_up(nv_run_o, 1'h0, 1'h0);
    check(run_o, 1'h1);
    fault(4'h5, 1'h1);
    wb(1'h1, OFS_CTRL, 32'h1);
    check(run_o, 1'h0);
    // stopped, code 5 active, serious lock set, retained run dropped
    wb(1'h0, OFS_STAT, 32'h0);
    check(q, 32'h550);
    fault_clear_i <= 1'h1;
    tick(1);
    fault_clear_i <= 1'h0;
    wb(1'h1, OFS_CTRL, 32'h3);
    check(run_o, 1'h1);
    check(nv_run_o, 1'h1);
    power_up(1'h0, 1'h1, 1'h1);
    check(run_o, 1'h1);
    power_up(1'h1, 1'h1, 1'h0);
    check(run_o, 1'h0);
    check(output_point_lamp_o[3:0], 4'h7);
    for (int k = 0; k < 4; k++) begin
      supply_good_i <= k[0];
      overload_i <= k[1];
      tick(2);
      check(supply_ok_lamp_o, k[0] & ~k[1]);
    end
    n = 0;
    m = 0;
    go <= 1'h1;
    tick(1);
    go <= 1'h0;
    repeat (40) begin
      @(posedge clk_i);
      n += (rx_lamp_o === 1'h1);
      m += (tx_lamp_o === 1'h1);
    end
    check(n, 5);
    check(m, 7);
    tally_and_finish;
  end
endmodule
`default_nettype wire
